/* File: port_pkg.sv */
package port_pkg;

	localparam int PORT_W = 8;

	// Special port bit positions
	localparam int SP_RXD  = 0;
	localparam int SP_TXD  = 1;
	localparam int SP_IRQ0 = 2;
	localparam int SP_IRQ1 = 3;
	localparam int SP_CNT0 = 4;
	localparam int SP_CNT1 = 5;
	localparam int SP_WRS  = 6;
	localparam int SP_RDS  = 7;

	// Latch value after reset: all ones, pins weakly high
	localparam logic [7:0] LATCH_RST = 8'hFF;

	// Reset qualification: two machine cycles of twelve oscillator clocks
	localparam int MACH_CYC_CLKS = 12;
	localparam int RST_MACH_CYC  = 2;
	localparam int RST_HOLD_CLKS = MACH_CYC_CLKS * RST_MACH_CYC;
	localparam logic [4:0] RST_CNT_ZERO = 5'h00;
	localparam logic [4:0] RST_CNT_ONE  = 5'h01;

	// Upper port source select
	typedef enum logic [1:0] {
		UP_LATCH = 2'b00,
		UP_ADDR  = 2'b01
	} up_src_t;

	// Core side controls
	typedef struct packed {
		logic       ext_fetch;     // Fetch from external program memory
		logic       long_access;   // long_pointer_data_access in progress
		logic       short_access;  // short_pointer_data_access in progress
		logic [7:0] addr_hi;       // High address byte
		logic       txd;           // Serial transmit alternate output
		logic       wr_n;          // Write strobe alternate output
		logic       rd_n;          // Read strobe alternate output
		logic       cc3_out;       // Capture/compare channel 3 output
		logic       cc4_out;       // Capture/compare channel 4 output
	} core_ctl_t;

	// Pin drive for one port
	typedef struct packed {
		logic [7:0] out;     // Level driven when enabled
		logic [7:0] oe;      // Strong drive enable
		logic [7:0] pu;      // Weak pull-up active
	} pin_drv_t;

	// Decoded special port inputs
	typedef struct packed {
		logic rxd;
		logic irq0;
		logic irq1;
		logic cnt0;
		logic cnt1;
		logic cc3_in;
		logic cc4_in;
	} sp_in_t;

endpackage

/* File: rst_qual.sv */
`timescale 1ns/1ps
module rst_qual #(
	parameter int HOLD = port_pkg::RST_HOLD_CLKS
) (
	input  wire logic clk_i,
	input  wire logic rst_pin_i,
	output logic      rst_o
);
	import port_pkg::*;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [4:0] cnt;
		logic       rst;
	} rq_t;

	rq_t st_ff;
	rq_t nxt_st;

	// Pin passes two flops, then must hold high HOLD clocks
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.s1  = rst_pin_i;
		nxt_st.s2  = st_ff.s1;
		if (!st_ff.s2) begin
			nxt_st.cnt = RST_CNT_ZERO;
			nxt_st.rst = 1'b0;
		end else if (st_ff.cnt != 5'(HOLD - 1)) begin
			nxt_st.cnt = st_ff.cnt + RST_CNT_ONE;
		end else begin
			nxt_st.rst = 1'b1;
		end
	end

	// State register; power up unknown settles within a few clocks
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign rst_o = st_ff.rst;

	// An unknown flag at power-up must not count as a rising edge
	hold_len_a: assert property (@(posedge clk_i) (st_ff.rst && !$past(st_ff.rst)) |-> $past(st_ff.s2, HOLD))
		else $error("reset asserted without full hold");
	short_pulse_a: assert property (@(posedge clk_i) !st_ff.s2 |=> !st_ff.rst)
		else $error("reset not released after pin low");
endmodule

/* File: port_pins.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Two ports, eight independent bidirectional pins each, weak pull-ups.
// - Latch bit one gives weak high, pin readable as input.
// - External fetch or long pointer access puts high address on upper port.
// - Address ones are driven strongly high.
// - Short pointer access keeps upper port latch on the pins.
// - Special bit 0 serial receive, bit 1 serial transmit.
// - Special bits 2 and 3 feed external interrupts zero and one.
// - Bits 4/5 are timer count inputs and capture channels 3/4.
// - Bits 6/7 carry data memory write and read strobes.
// - Reset pin must stay high two machine cycles to reset.
module port_pins (
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	input  wire logic              UP_WE_I,
	input  wire logic [7:0]        UP_WDATA_I,
	input  wire logic              SP_WE_I,
	input  wire logic [7:0]        SP_WDATA_I,
	input  wire port_pkg::core_ctl_t CTL_I,
	input  wire logic [7:0]        UP_PIN_I,
	input  wire logic [7:0]        SP_PIN_I,
	output port_pkg::pin_drv_t     UP_DRV_O,
	output port_pkg::pin_drv_t     SP_DRV_O,
	output logic [7:0]             UP_RD_O,
	output logic [7:0]             SP_RD_O,
	output logic [7:0]             UP_LATCH_O,
	output logic [7:0]             SP_LATCH_O,
	output port_pkg::sp_in_t       SP_IN_O,
	output logic                   DEV_RST_O
);
	import port_pkg::*;

	typedef struct packed {
		logic [7:0] up_latch;   // upper_port_latch
		logic [7:0] sp_latch;   // special_port latch
		logic [7:0] up_s1;
		logic [7:0] up_s2;
		logic [7:0] sp_s1;
		logic [7:0] sp_s2;
		pin_drv_t   up_drv;
		pin_drv_t   sp_drv;
		sp_in_t     sp_in;
		logic       rst_d;      // Qualified reset one edge late
	} st_t;

	st_t     st_ff;
	st_t     nxt_st;
	logic    core_rst;
	up_src_t up_src;
	logic [7:0] sp_alt;

	// Reset pin qualification
	rst_qual #(
		.HOLD (RST_HOLD_CLKS)
	) u_rst_qual (
		.clk_i     (CLK_I),
		.rst_pin_i (RST_I),
		.rst_o     (core_rst)
	);

	// Quasi-bidirectional drive: zero strong low, one weak high
	function automatic pin_drv_t quasi(input logic [7:0] val);
		pin_drv_t d;
		d.out = 8'h00;
		d.oe  = ~val;
		d.pu  = val;
		return d;
	endfunction

	// Upper port source: address wins only for fetch or long access
	always_comb begin
		if (CTL_I.ext_fetch || CTL_I.long_access) begin
			up_src = UP_ADDR;
		end else begin
			up_src = UP_LATCH;
		end
	end

	// Alternate outputs; input-only functions idle high
	always_comb begin
		sp_alt          = 8'hFF;
		sp_alt[SP_TXD]  = CTL_I.txd;
		sp_alt[SP_CNT0] = CTL_I.cc3_out;
		sp_alt[SP_CNT1] = CTL_I.cc4_out;
		sp_alt[SP_WRS]  = CTL_I.wr_n;
		sp_alt[SP_RDS]  = CTL_I.rd_n;
	end

	// Next state: latches, pin synchronisers, drive and decode
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.up_s1 = UP_PIN_I;
		nxt_st.up_s2 = st_ff.up_s1;
		nxt_st.sp_s1 = SP_PIN_I;
		nxt_st.sp_s2 = st_ff.sp_s1;
		nxt_st.rst_d = core_rst; // Port state holds reset values one edge after release
		if (UP_WE_I) begin
			nxt_st.up_latch = UP_WDATA_I;
		end
		if (SP_WE_I) begin
			nxt_st.sp_latch = SP_WDATA_I;
		end
		case (up_src)
			UP_ADDR: begin
				nxt_st.up_drv.out = CTL_I.addr_hi;
				nxt_st.up_drv.oe  = 8'hFF;
				nxt_st.up_drv.pu  = 8'h00;
			end
			UP_LATCH: begin
				nxt_st.up_drv = quasi(st_ff.up_latch);
			end
			default: begin
				nxt_st.up_drv = quasi(LATCH_RST);
			end
		endcase
		nxt_st.sp_drv       = quasi(st_ff.sp_latch & sp_alt);
		nxt_st.sp_in.rxd    = st_ff.sp_s2[SP_RXD];
		nxt_st.sp_in.irq0   = st_ff.sp_s2[SP_IRQ0];
		nxt_st.sp_in.irq1   = st_ff.sp_s2[SP_IRQ1];
		nxt_st.sp_in.cnt0   = st_ff.sp_s2[SP_CNT0];
		nxt_st.sp_in.cnt1   = st_ff.sp_s2[SP_CNT1];
		nxt_st.sp_in.cc3_in = st_ff.sp_s2[SP_CNT0];
		nxt_st.sp_in.cc4_in = st_ff.sp_s2[SP_CNT1];
		if (core_rst) begin
			nxt_st.up_latch = LATCH_RST;
			nxt_st.sp_latch = LATCH_RST;
			nxt_st.up_drv   = quasi(LATCH_RST);
			nxt_st.sp_drv   = quasi(LATCH_RST);
			nxt_st.sp_in    = '1;
		end
	end

	// State register
	always_ff @(posedge CLK_I) begin
		st_ff <= nxt_st;
	end

	// Outputs straight from flops
	assign UP_DRV_O   = st_ff.up_drv;
	assign SP_DRV_O   = st_ff.sp_drv;
	assign UP_RD_O    = st_ff.up_s2;
	assign SP_RD_O    = st_ff.sp_s2;
	assign UP_LATCH_O = st_ff.up_latch;
	assign SP_LATCH_O = st_ff.sp_latch;
	assign SP_IN_O    = st_ff.sp_in;
	assign DEV_RST_O  = core_rst;

	// Checks; port state lags the qualified reset by one edge, so checks wait that edge out
	addr_drive_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		(CTL_I.ext_fetch || CTL_I.long_access) |=> (UP_DRV_O.oe == 8'hFF && UP_DRV_O.out == $past(CTL_I.addr_hi)))
		else $error("upper port not driving address");
	strong_one_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		CTL_I.long_access |=> UP_DRV_O.pu == 8'h00)
		else $error("weak pull-up used for address");
	short_latch_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		(CTL_I.short_access && !CTL_I.ext_fetch && !CTL_I.long_access)
		|=> UP_DRV_O.pu == $past(st_ff.up_latch))
		else $error("latch not kept on short access");
	weak_high_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		(UP_DRV_O.pu & UP_DRV_O.oe) == 8'h00)
		else $error("pin both pulled and driven");
	alt_and_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_DRV_O.pu[SP_WRS] == ($past(st_ff.sp_latch[SP_WRS]) && $past(CTL_I.wr_n)))
		else $error("write strobe not gated by latch");
	txd_out_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_DRV_O.oe[SP_TXD] == !($past(st_ff.sp_latch[SP_TXD]) && $past(CTL_I.txd)))
		else $error("transmit pin wrong");
	irq_path_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> ##2 SP_IN_O.irq0 == $past(SP_PIN_I[SP_IRQ0], 3))
		else $error("interrupt input latency wrong");
	latch_write_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		UP_WE_I |=> UP_LATCH_O == $past(UP_WDATA_I))
		else $error("upper latch write lost");
	sp_latch_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		SP_WE_I |=> SP_LATCH_O == $past(SP_WDATA_I))
		else $error("special latch write lost");

	// Upper port source selection and drive strength
	fetch_strong_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		CTL_I.ext_fetch |=>
		(UP_DRV_O.pu == 8'h00 && UP_DRV_O.out == $past(CTL_I.addr_hi)))
		else $error("fetch address not strongly driven");
	up_quasi_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		(!CTL_I.ext_fetch && !CTL_I.long_access) |=> UP_DRV_O.oe == ~$past(st_ff.up_latch))
		else $error("upper port not quasi driven from latch");

	// Pin read-back through the two synchroniser stages
	up_read_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		UP_RD_O == $past(UP_PIN_I, 2))
		else $error("upper pin read-back wrong");
	sp_read_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		SP_RD_O == $past(SP_PIN_I, 2))
		else $error("special pin read-back wrong");

	// Special port input functions, three clocks behind the pin
	rxd_path_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_IN_O.rxd == $past(SP_PIN_I[SP_RXD], 3))
		else $error("receive input latency wrong");
	irq_one_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_IN_O.irq1 == $past(SP_PIN_I[SP_IRQ1], 3))
		else $error("second interrupt input wrong");
	count_in_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> (SP_IN_O.cnt0 == $past(SP_PIN_I[SP_CNT0], 3)
		&& SP_IN_O.cc4_in == $past(SP_PIN_I[SP_CNT1], 3)))
		else $error("count or capture input wrong");

	// Alternate outputs need their latch bit set
	rd_gate_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_DRV_O.pu[SP_RDS] == ($past(st_ff.sp_latch[SP_RDS]) && $past(CTL_I.rd_n)))
		else $error("read strobe not gated by latch");
	cc3_out_a: assert property (@(posedge CLK_I) disable iff (core_rst || st_ff.rst_d)
		1'b1 |=> SP_DRV_O.oe[SP_CNT0] == !($past(st_ff.sp_latch[SP_CNT0]) && $past(CTL_I.cc3_out)))
		else $error("capture channel output wrong");

	// Reset loads all ones into both latches and leaves the pins to the pull-ups
	rst_values_a: assert property (@(posedge CLK_I)
		core_rst |=> (UP_LATCH_O == LATCH_RST && SP_LATCH_O == LATCH_RST && SP_DRV_O.pu == LATCH_RST))
		else $error("reset values not loaded");

	addr_cov: cover property (@(posedge CLK_I) CTL_I.long_access ##1 UP_DRV_O.oe == 8'hFF);
	short_cov: cover property (@(posedge CLK_I) CTL_I.short_access && !CTL_I.long_access);
	rst_cov: cover property (@(posedge CLK_I) $rose(core_rst));
	strobe_cov: cover property (@(posedge CLK_I) !CTL_I.wr_n ##1 SP_DRV_O.oe[SP_WRS]);
	fetch_cov: cover property (@(posedge CLK_I) CTL_I.ext_fetch ##1 UP_DRV_O.pu == 8'h00);
endmodule

/* File: board_model.sv */
`timescale 1ns/1ps
module board_model (
	input  wire logic               clk_i,
	input  wire port_pkg::pin_drv_t drv_i,
	input  wire logic [7:0]         low_i,
	output logic [7:0]              pin_o
);
	import port_pkg::*;
	logic [7:0] junk_ff = 8'h00;
	// Undriven lines show a changing pattern, not a stale level
	always_ff @(posedge clk_i) junk_ff <= ~junk_ff;
	// Strong drive wins, then an outside pull-down, then the weak pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_o[i] = drv_i.oe[i] ? drv_i.out[i] : low_i[i] ? 1'b0 : drv_i.pu[i] ? 1'b1 : junk_ff[i];
		end
	end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import port_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, up_we = 1'b0, sp_we = 1'b0, dev_rst;
	logic [7:0] up_wd = 8'h00, sp_wd = 8'h00, up_low = 8'h00, sp_low = 8'h00;
	logic [7:0] up_pin, sp_pin, up_rd, sp_rd, up_lat, sp_lat, uv, sv, a, ep;
	logic [2:0] m;
	core_ctl_t  ctl = {3'b000, 8'h00, 5'h1F};
	pin_drv_t   up_drv, sp_drv, eu;
	sp_in_t     sp_in;
	int         failures = 0, tests_run = 0, cyc = 0;

	always #20 clk = ~clk;

	port_pins dut_u (.CLK_I(clk), .RST_I(rst), .UP_WE_I(up_we), .UP_WDATA_I(up_wd), .SP_WE_I(sp_we),
		.SP_WDATA_I(sp_wd), .CTL_I(ctl), .UP_PIN_I(up_pin), .SP_PIN_I(sp_pin), .UP_DRV_O(up_drv),
		.SP_DRV_O(sp_drv), .UP_RD_O(up_rd), .SP_RD_O(sp_rd), .UP_LATCH_O(up_lat), .SP_LATCH_O(sp_lat),
		.SP_IN_O(sp_in), .DEV_RST_O(dev_rst));
	board_model up_b (.clk_i(clk), .drv_i(up_drv), .low_i(up_low), .pin_o(up_pin));
	board_model sp_b (.clk_i(clk), .drv_i(sp_drv), .low_i(sp_low), .pin_o(sp_pin));

	// Weakly pulled port pattern for a latch value
	function automatic pin_drv_t quasi(logic [7:0] v);
		return {8'h00, ~v, v};
	endfunction

	// Alternate outputs laid over the special port bits
	function automatic logic [7:0] alt(core_ctl_t c);
		return {c.rd_n, c.wr_n, c.cc4_out, c.cc3_out, 2'b11, c.txd, 1'b1};
	endfunction

	task automatic chk(string n, logic [23:0] e, logic [23:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic settle();
		repeat (6) @(negedge clk);
	endtask

	// Hold reset for a given count, then let it drop; two sync stages plus the hold must pass
	task automatic pulse(int n);
		rst = 1'b1;
		repeat (n) @(negedge clk);
		chk("dev_rst_held", 24'(n >= RST_HOLD_CLKS + 2), 24'(dev_rst));
		rst = 1'b0;
		settle();
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		void'($urandom(82));
		pulse(30);
		chk("up_drv", quasi(8'hFF), up_drv);
		chk("sp_lat", 24'(8'hFF), 24'(sp_lat));
		for (int k = 0; k < 24; k++) begin
			uv = 8'($urandom);
			sv = 8'($urandom);
			a = 8'($urandom);
			if (k == 0) uv = 8'h00;
			if (k == 1) sv = 8'h00;
			up_low = 8'($urandom);
			sp_low = 8'($urandom);
			m = 3'(4'b1000 >> (k % 4));
			ctl = {m, a, 5'($urandom)};
			up_wd = uv;
			sp_wd = sv;
			up_we = 1'b1;
			sp_we = 1'b1;
			@(negedge clk);
			up_we = 1'b0;
			sp_we = 1'b0;
			settle();
			chk("up_lat", 24'(uv), 24'(up_lat));
			chk("sp_lat", 24'(sv), 24'(sp_lat));
			eu = (m[2] | m[1]) ? {a, 8'hFF, 8'h00} : quasi(uv);
			chk("up_drv", eu, up_drv);
			chk("up_rd", 24'((m[2] | m[1]) ? a : uv & ~up_low), 24'(up_rd));
			chk("sp_drv", quasi(sv & alt(ctl)), sp_drv);
			ep = sv & alt(ctl) & ~sp_low;
			chk("sp_rd", 24'(ep), 24'(sp_rd));
			chk("sp_in", 24'({ep[0], ep[2], ep[3], ep[4], ep[5], ep[4], ep[5]}), 24'(sp_in));
		end
		pulse(5);
		chk("dev_rst", 24'(1'b0), 24'(dev_rst));
		chk("sp_lat", 24'(sv), 24'(sp_lat));
		pulse(30);
		chk("sp_lat", 24'(8'hFF), 24'(sp_lat));
		test_done();
	end
endmodule
